// ===== hw/spc_dev.sv
// device end: serial word receiver, configuration words, decode and readback
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
// Contract
// RULE1: noise code 00 low noise, 11 dither
// RULE2: pin multiplexer drives six sources
// RULE3: reference halving bit, reset off
// RULE4: reference divider 1..1023, never zero
// RULE5: double buffer holds output divider
// RULE6: lock count 40 or 5 cycles
// RULE7: lock window 10ns or 6ns
// RULE8: detector polarity, resets positive
// RULE9: charge pump tristate bit, reset off
// RULE10: codes 010 and 011 select words
// RULE11: band search rate low or high
// RULE12: host keeps band divider at most 254 at high rate
// RULE13: timer mode off, fast lock, resync
// RULE14: timer divider 1..4095, never zero
// RULE15: feedback source select, resets fundamental
// RULE16: output divider two to the code
// RULE17: code 100 loads output word
// RULE18: band clock divides reference divider ticks
// RULE19: readback shifts most significant first
// RULE20: commit on release after whole word
module spc_dev (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	spc_link_if.dev LINK,
	input wire logic REF_DIV_TICK,
	input wire logic FB_DIV_TICK,
	input wire logic LOCK_DETECT,
	output logic LOW_SPUR_MODE,
	output logic DITHER_ENABLE,
	output logic REF_DOUBLER_ENABLE,
	output logic REF_HALVING_ENABLE,
	output logic [9:0] REF_DIVIDE,
	output logic [3:0] CHARGE_PUMP_CURRENT,
	output logic [5:0] LOCK_COUNT,
	output logic [3:0] LOCK_WINDOW_NS,
	output logic PD_POSITIVE,
	output logic SYNTH_POWER_DOWN,
	output logic CHARGE_PUMP_TRISTATE,
	output logic BAND_RATE_HIGH,
	output logic TIMER_FAST_LOCK,
	output logic TIMER_RESYNC,
	output logic [11:0] TIMER_DIVIDE,
	output logic FEEDBACK_FUNDAMENTAL,
	output logic [6:0] OUTPUT_DIVIDE_RATIO,
	output logic BAND_CLOCK_TICK,
	output logic OSC_POWER_OFF,
	output logic MUTE_UNTIL_LOCK,
	output logic OUTB_SELECT,
	output logic OUTB_ENABLE,
	output logic [1:0] OUTB_POWER,
	output logic OUTA_ENABLE,
	output logic [1:0] OUTA_POWER
);
	// {cs_n, sclk, sdata}
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] prev;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic [31:0] rx;
	logic [5:0] bit_cnt;
	logic take;
	logic [2:0] code;
	logic [31:0] ref_w;
	logic [31:0] band_w;
	logic [31:0] out_w;
	logic [2:0] odiv_act;
	logic [2:0] rb_sel;
	logic [31:0] rb_shift;
	logic [7:0] bs_cnt;
	logic [7:0] bs_div;

	// link pins come from another clock, two flops before use
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1 <= 3'h4;
			sync2 <= 3'h4;
			prev <= 3'h4;
		end else if (CLK_EN) begin
			sync1 <= {LINK.cs_n, LINK.sclk, LINK.sdata};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	assign sclk_rise = sync2[1] & ~prev[1] & ~sync2[2];
	assign sclk_fall = ~sync2[1] & prev[1] & ~sync2[2];
	assign cs_fall = ~sync2[2] & prev[2];
	assign cs_rise = sync2[2] & ~prev[2];
	// RULE20: whole word only
	assign take = cs_rise && (bit_cnt == spc_pkg::WORD_BITS_CNT);
	assign code = rx[spc_pkg::CODE_LSB +: 3];
	assign bs_div = out_w[spc_pkg::BSDIV_LSB +: 8];

	// count saturates above a word so an overlong frame is never taken
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx <= 32'h0000_0000;
			bit_cnt <= 6'h00;
		end else if (CLK_EN) begin
			if (cs_fall) begin
				bit_cnt <= 6'h00;
			end else if (sclk_rise) begin
				rx <= {rx[30:0], sync2[0]};
				if (bit_cnt <= spc_pkg::WORD_BITS_CNT) begin
					bit_cnt <= bit_cnt + 6'h01;
				end
			end
		end
	end

	// configuration words, reserved positions masked off
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_w <= spc_pkg::REF_RESET;
			band_w <= spc_pkg::BAND_RESET;
			out_w <= spc_pkg::OUT_RESET;
			rb_sel <= spc_pkg::CODE_REF;
		end else if (CLK_EN && take) begin
			// RULE10: load selected word
			case (code)
				spc_pkg::CODE_REF: begin
					// RULE4: zero divider refused
					if (rx[spc_pkg::RDIV_LSB +: 10] != 10'h000) begin
						ref_w <= rx & spc_pkg::REF_MASK;
						rb_sel <= code;
					end
				end
				spc_pkg::CODE_BAND: begin
					// RULE14: zero divider refused
					if (rx[spc_pkg::TDIV_LSB +: 12] != 12'h000) begin
						band_w <= rx & spc_pkg::BAND_MASK;
						rb_sel <= code;
					end
				end
				// RULE17: output word load
				spc_pkg::CODE_OUT: begin
					out_w <= rx & spc_pkg::OUT_MASK;
					rb_sel <= code;
				end
				default: begin
				end
			endcase
		end
	end

	// RULE5: buffered divider waits for integer word
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			odiv_act <= 3'h0;
		end else if (CLK_EN && take) begin
			if (code == spc_pkg::CODE_OUT && !ref_w[spc_pkg::DBUF_BIT]) begin
				odiv_act <= rx[spc_pkg::ODIV_LSB +: 3];
			end else if (code == spc_pkg::CODE_INT_WORD) begin
				odiv_act <= out_w[spc_pkg::ODIV_LSB +: 3];
			end
		end
	end

	// decoded reference / lock controls
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LOW_SPUR_MODE <= 1'b0;
			DITHER_ENABLE <= 1'b0;
			REF_DOUBLER_ENABLE <= 1'b0;
			REF_HALVING_ENABLE <= 1'b0;
			REF_DIVIDE <= 10'h001;
			CHARGE_PUMP_CURRENT <= 4'h0;
			LOCK_COUNT <= spc_pkg::LOCK_COUNT_SLOW;
			LOCK_WINDOW_NS <= spc_pkg::LOCK_WIN_WIDE_NS;
			PD_POSITIVE <= 1'b1;
			SYNTH_POWER_DOWN <= 1'b0;
			CHARGE_PUMP_TRISTATE <= 1'b0;
		end else if (CLK_EN) begin
			// RULE1: reserved noise codes change nothing
			if (ref_w[spc_pkg::NOISE_LSB +: 2] == spc_pkg::NOISE_SPUR) begin
				LOW_SPUR_MODE <= 1'b1;
				DITHER_ENABLE <= 1'b1;
			end else if (ref_w[spc_pkg::NOISE_LSB +: 2] == spc_pkg::NOISE_LOW) begin
				LOW_SPUR_MODE <= 1'b0;
				DITHER_ENABLE <= 1'b0;
			end
			REF_DOUBLER_ENABLE <= ref_w[spc_pkg::REFDBL_BIT];
			// RULE3: halving stage
			REF_HALVING_ENABLE <= ref_w[spc_pkg::HALVE_BIT];
			// RULE4: divide by binary value
			REF_DIVIDE <= ref_w[spc_pkg::RDIV_LSB +: 10];
			CHARGE_PUMP_CURRENT <= ref_w[spc_pkg::CP_LSB +: 4];
			// RULE6: lock cycle count
			LOCK_COUNT <= ref_w[spc_pkg::LCNT_BIT] ? spc_pkg::LOCK_COUNT_FAST : spc_pkg::LOCK_COUNT_SLOW;
			// RULE7: lock window
			LOCK_WINDOW_NS <= ref_w[spc_pkg::LWIN_BIT] ? spc_pkg::LOCK_WIN_NARROW_NS : spc_pkg::LOCK_WIN_WIDE_NS;
			// RULE8: detector polarity
			PD_POSITIVE <= ref_w[spc_pkg::PDPOL_BIT];
			SYNTH_POWER_DOWN <= ref_w[spc_pkg::PWRDN_BIT];
			// RULE9: charge pump release
			CHARGE_PUMP_TRISTATE <= ref_w[spc_pkg::CPTRI_BIT];
		end
	end

	// decoded band, timer and output controls
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			BAND_RATE_HIGH <= 1'b0;
			TIMER_FAST_LOCK <= 1'b0;
			TIMER_RESYNC <= 1'b0;
			TIMER_DIVIDE <= 12'h001;
			FEEDBACK_FUNDAMENTAL <= 1'b1;
			OUTPUT_DIVIDE_RATIO <= spc_pkg::ODIV_RESET_RATIO;
			OSC_POWER_OFF <= 1'b0;
			MUTE_UNTIL_LOCK <= 1'b0;
			OUTB_SELECT <= 1'b0;
			OUTB_ENABLE <= 1'b0;
			OUTB_POWER <= 2'h2;
			OUTA_ENABLE <= 1'b0;
			OUTA_POWER <= 2'h2;
		end else if (CLK_EN) begin
			// RULE11: band search rate
			BAND_RATE_HIGH <= band_w[spc_pkg::RATE_BIT];
			// RULE13: timer mode, reserved code is off
			TIMER_FAST_LOCK <= band_w[spc_pkg::TMODE_LSB +: 2] == spc_pkg::TMODE_FAST_LOCK;
			TIMER_RESYNC <= band_w[spc_pkg::TMODE_LSB +: 2] == spc_pkg::TMODE_RESYNC;
			// RULE14: timer divide value
			TIMER_DIVIDE <= band_w[spc_pkg::TDIV_LSB +: 12];
			// RULE15: feedback source
			FEEDBACK_FUNDAMENTAL <= out_w[spc_pkg::FBSEL_BIT];
			// RULE16: ratio, reserved code keeps last
			if (odiv_act != spc_pkg::ODIV_RESERVED) begin
				OUTPUT_DIVIDE_RATIO <= 7'h01 << odiv_act;
			end
			OSC_POWER_OFF <= out_w[spc_pkg::OSCOFF_BIT];
			MUTE_UNTIL_LOCK <= out_w[spc_pkg::MUTE_BIT];
			OUTB_SELECT <= out_w[spc_pkg::BSEL_BIT];
			// second output needs the first one on too
			OUTB_ENABLE <= out_w[spc_pkg::BEN_BIT] & out_w[spc_pkg::AEN_BIT];
			OUTB_POWER <= out_w[spc_pkg::BPWR_LSB +: 2];
			OUTA_ENABLE <= out_w[spc_pkg::AEN_BIT];
			OUTA_POWER <= out_w[spc_pkg::APWR_LSB +: 2];
		end
	end

	// RULE18: band clock from reference ticks
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bs_cnt <= 8'h00;
			BAND_CLOCK_TICK <= 1'b0;
		end else if (CLK_EN) begin
			BAND_CLOCK_TICK <= 1'b0;
			if (REF_DIV_TICK) begin
				if (bs_cnt >= bs_div - 8'h01) begin
					bs_cnt <= 8'h00;
					BAND_CLOCK_TICK <= 1'b1;
				end else begin
					bs_cnt <= bs_cnt + 8'h01;
				end
			end
		end
	end

	// RULE19: readback most significant first
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rb_shift <= 32'h0000_0000;
		end else if (CLK_EN) begin
			if (cs_fall) begin
				case (rb_sel)
					spc_pkg::CODE_BAND: rb_shift <= band_w;
					spc_pkg::CODE_OUT: rb_shift <= out_w;
					default: rb_shift <= ref_w;
				endcase
			end else if (sclk_fall) begin
				rb_shift <= {rb_shift[30:0], 1'b0};
			end
		end
	end

	// RULE2: pin multiplexer, reserved code floats
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.pin_output_mux_select <= 1'b0;
			LINK.mux_oe <= 1'b0;
		end else if (CLK_EN) begin
			LINK.mux_oe <= 1'b1;
			case (ref_w[spc_pkg::MUX_LSB +: 3])
				spc_pkg::MUX_HIGH: LINK.pin_output_mux_select <= 1'b1;
				spc_pkg::MUX_LOW: LINK.pin_output_mux_select <= 1'b0;
				spc_pkg::MUX_REFDIV: LINK.pin_output_mux_select <= REF_DIV_TICK;
				spc_pkg::MUX_FBDIV: LINK.pin_output_mux_select <= FB_DIV_TICK;
				spc_pkg::MUX_LOCK: LINK.pin_output_mux_select <= LOCK_DETECT;
				spc_pkg::MUX_READBACK: LINK.pin_output_mux_select <= rb_shift[31];
				default: begin
					LINK.pin_output_mux_select <= 1'b0;
					LINK.mux_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule // spc_dev

// ===== common/spc_pkg.sv
// shared constants for the synthesizer configuration link and its two ends
package spc_pkg;
	// target codes in the low three bits of every word
	localparam logic [2:0] CODE_INT_WORD = 3'h0;
	localparam logic [2:0] CODE_REF = 3'h2;
	localparam logic [2:0] CODE_BAND = 3'h3;
	localparam logic [2:0] CODE_OUT = 3'h4;
	localparam int CODE_LSB = 0;
	localparam int WORD_BITS = 32;
	localparam logic [5:0] WORD_BITS_CNT = 6'h20;

	// reference / lock word fields
	localparam int NOISE_LSB = 29;
	localparam int MUX_LSB = 26;
	localparam int REFDBL_BIT = 25;
	localparam int HALVE_BIT = 24;
	localparam int RDIV_LSB = 14;
	localparam int DBUF_BIT = 13;
	localparam int CP_LSB = 9;
	localparam int LCNT_BIT = 8;
	localparam int LWIN_BIT = 7;
	localparam int PDPOL_BIT = 6;
	localparam int PWRDN_BIT = 5;
	localparam int CPTRI_BIT = 4;
	localparam logic [31:0] REF_MASK = 32'h7fff_fff7;
	localparam logic [31:0] REF_RESET = 32'h0000_4042;

	// band-select / timer word fields
	localparam int TDIV_LSB = 3;
	localparam int TMODE_LSB = 15;
	localparam int RATE_BIT = 23;
	localparam logic [31:0] BAND_MASK = 32'h0081_ffff;
	localparam logic [31:0] BAND_RESET = 32'h0000_000b;

	// output / feedback word fields
	localparam int FBSEL_BIT = 23;
	localparam int ODIV_LSB = 20;
	localparam int BSDIV_LSB = 12;
	localparam int OSCOFF_BIT = 11;
	localparam int MUTE_BIT = 10;
	localparam int BSEL_BIT = 9;
	localparam int BEN_BIT = 8;
	localparam int BPWR_LSB = 6;
	localparam int AEN_BIT = 5;
	localparam int APWR_LSB = 3;
	localparam logic [31:0] OUT_MASK = 32'h00ff_ffff;
	localparam logic [31:0] OUT_RESET = 32'h0080_1094;

	// field encodings
	localparam logic [1:0] NOISE_LOW = 2'h0;
	localparam logic [1:0] NOISE_SPUR = 2'h3;
	localparam logic [2:0] MUX_HIZ = 3'h0;
	localparam logic [2:0] MUX_HIGH = 3'h1;
	localparam logic [2:0] MUX_LOW = 3'h2;
	localparam logic [2:0] MUX_REFDIV = 3'h3;
	localparam logic [2:0] MUX_FBDIV = 3'h4;
	localparam logic [2:0] MUX_LOCK = 3'h6;
	localparam logic [2:0] MUX_READBACK = 3'h7;
	localparam logic [1:0] TMODE_FAST_LOCK = 2'h1;
	localparam logic [1:0] TMODE_RESYNC = 2'h2;
	localparam logic [2:0] ODIV_RESERVED = 3'h7;
	localparam logic [5:0] LOCK_COUNT_SLOW = 6'h28;
	localparam logic [5:0] LOCK_COUNT_FAST = 6'h05;
	localparam logic [3:0] LOCK_WIN_WIDE_NS = 4'ha;
	localparam logic [3:0] LOCK_WIN_NARROW_NS = 4'h6;
	localparam logic [7:0] BSDIV_MAX_FAST = 8'hfe;
	localparam logic [6:0] ODIV_RESET_RATIO = 7'h01;

	// host side: serial clock half period in system cycles, register offsets
	localparam logic [15:0] SCLK_HALF_CYCLES = 16'h0008;
	localparam logic [3:0] ADDR_TX = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RX = 4'h8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
endpackage

// ===== common/spc_link_if.sv
// three-wire configuration link plus the multiplexed readback pin
`timescale 1ns/1ns
interface spc_link_if;
	logic sclk;
	logic sdata;
	logic cs_n;
	logic pin_output_mux_select;
	logic mux_oe;
	logic mux_level;

	// released pin reads low
	assign mux_level = mux_oe ? pin_output_mux_select : 1'b0;

	modport dev (
		input sclk,
		input sdata,
		input cs_n,
		output pin_output_mux_select,
		output mux_oe
	);
	modport host (
		output sclk,
		output sdata,
		output cs_n,
		input mux_level
	);
endinterface

// ===== hw/spc_host.sv
// host end: avalon-mm command registers driving the three-wire link
`timescale 1ns/1ns
module spc_host #(
	parameter logic [15:0] SCLK_HALF = spc_pkg::SCLK_HALF_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic [3:0] AV_ADDRESS,
	input wire logic AV_READ,
	input wire logic AV_WRITE,
	input wire logic [31:0] AV_WRITEDATA,
	output logic [31:0] AV_READDATA,
	output logic AV_WAITREQUEST,
	spc_link_if.host LINK
);
	typedef enum logic [2:0] {SPC_IDLE, SPC_LEAD, SPC_LOW, SPC_HIGH, SPC_TAIL, SPC_GAP} spc_state_e;

	spc_state_e state;
	logic [15:0] tmr;
	logic [4:0] bit_idx;
	logic [31:0] tx_shift;
	logic [31:0] tx_word;
	logic [31:0] rx_shift;
	logic [31:0] rx_word;
	logic busy;
	logic refused;
	logic fast_rate;
	logic mux_s1;
	logic mux_s2;
	logic acc_wr;
	logic start;
	logic bad;
	logic half_done;

	function automatic logic spc_refuse(input logic [31:0] w, input logic fast);
		case (w[spc_pkg::CODE_LSB +: 3])
			// RULE4: never a zero reference divider
			spc_pkg::CODE_REF: spc_refuse = w[spc_pkg::RDIV_LSB +: 10] == 10'h000;
			// RULE14: never a zero timer divider
			spc_pkg::CODE_BAND: spc_refuse = w[spc_pkg::TDIV_LSB +: 12] == 12'h000;
			// RULE12: band divider bound at high rate
			spc_pkg::CODE_OUT: spc_refuse = fast && (w[spc_pkg::BSDIV_LSB +: 8] > spc_pkg::BSDIV_MAX_FAST);
			default: spc_refuse = 1'b0;
		endcase
	endfunction

	assign acc_wr = AV_WRITE && !AV_WAITREQUEST;
	assign bad = spc_refuse(AV_WRITEDATA, fast_rate);
	assign start = acc_wr && AV_ADDRESS == spc_pkg::ADDR_TX && !bad;
	assign half_done = tmr >= SCLK_HALF - 16'h0001;

	// one wait cycle, then a single low cycle; a word write stalls while a frame runs
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			AV_WAITREQUEST <= 1'b1;
			AV_READDATA <= 32'h0000_0000;
		end else if (CLK_EN) begin
			AV_WAITREQUEST <= 1'b1;
			if (AV_WAITREQUEST && (AV_READ || (AV_WRITE && !(AV_ADDRESS == spc_pkg::ADDR_TX && busy)))) begin
				AV_WAITREQUEST <= 1'b0;
				case (AV_ADDRESS)
					spc_pkg::ADDR_TX: AV_READDATA <= tx_word;
					spc_pkg::ADDR_STATUS: AV_READDATA <= {30'h0, refused, busy};
					spc_pkg::ADDR_RX: AV_READDATA <= rx_word;
					default: AV_READDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// refused flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			refused <= 1'b0;
			fast_rate <= 1'b0;
			tx_word <= 32'h0000_0000;
		end else if (CLK_EN) begin
			if (acc_wr && AV_ADDRESS == spc_pkg::ADDR_TX && bad) begin
				refused <= 1'b1;
			end else if (acc_wr && AV_ADDRESS == spc_pkg::ADDR_STATUS && AV_WRITEDATA[spc_pkg::STAT_REFUSED_BIT]) begin
				refused <= 1'b0;
			end
			if (start) begin
				tx_word <= AV_WRITEDATA;
				if (AV_WRITEDATA[spc_pkg::CODE_LSB +: 3] == spc_pkg::CODE_BAND) begin
					fast_rate <= AV_WRITEDATA[spc_pkg::RATE_BIT];
				end
			end
		end
	end

	// readback pin is asynchronous to us
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mux_s1 <= 1'b0;
			mux_s2 <= 1'b0;
		end else if (CLK_EN) begin
			mux_s1 <= LINK.mux_level;
			mux_s2 <= mux_s1;
		end
	end

	// RULE10: word with its target code goes out msb first
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= SPC_IDLE;
			tmr <= 16'h0000;
			bit_idx <= 5'h00;
			tx_shift <= 32'h0000_0000;
			rx_shift <= 32'h0000_0000;
			rx_word <= 32'h0000_0000;
			busy <= 1'b0;
			LINK.sclk <= 1'b0;
			LINK.sdata <= 1'b0;
			LINK.cs_n <= 1'b1;
		end else if (CLK_EN) begin
			tmr <= half_done ? 16'h0000 : tmr + 16'h0001;
			case (state)
				SPC_IDLE: begin
					tmr <= 16'h0000;
					if (start) begin
						busy <= 1'b1;
						tx_shift <= AV_WRITEDATA;
						LINK.sdata <= AV_WRITEDATA[31];
						LINK.cs_n <= 1'b0;
						bit_idx <= 5'h00;
						state <= SPC_LEAD;
					end
				end
				SPC_LEAD, SPC_LOW: begin
					if (half_done) begin
						LINK.sclk <= 1'b1;
						state <= SPC_HIGH;
					end
				end
				SPC_HIGH: begin
					if (half_done) begin
						// RULE19: readback taken msb first
						rx_shift <= {rx_shift[30:0], mux_s2};
						LINK.sclk <= 1'b0;
						if (bit_idx == 5'h1f) begin
							state <= SPC_TAIL;
						end else begin
							tx_shift <= {tx_shift[30:0], 1'b0};
							LINK.sdata <= tx_shift[30];
							bit_idx <= bit_idx + 5'h01;
							state <= SPC_LOW;
						end
					end
				end
				SPC_TAIL: begin
					if (half_done) begin
						// RULE20: release after full word commits it
						LINK.cs_n <= 1'b1;
						rx_word <= rx_shift;
						state <= SPC_GAP;
					end
				end
				SPC_GAP: begin
					if (half_done) begin
						busy <= 1'b0;
						state <= SPC_IDLE;
					end
				end
				default: state <= SPC_IDLE;
			endcase
		end
	end
endmodule // spc_host

// ===== testbench/spc_chk.sv
// wire-level checks on the three-wire configuration link
`timescale 1ns/1ns
module spc_chk #(
	parameter logic [15:0] SCLK_HALF = spc_pkg::SCLK_HALF_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic cs_n,
	input wire logic pin_output_mux_select,
	input wire logic mux_oe,
	input wire logic mux_level
);
	logic sclk_q;
	logic [15:0] high_cnt;
	logic [15:0] low_cnt;
	logic [5:0] rise_cnt;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) sclk_q <= 1'b0;
		else sclk_q <= sclk;
	end
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) high_cnt <= 16'h0;
		else high_cnt <= sclk ? high_cnt + 16'h1 : 16'h0;
	end
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) low_cnt <= 16'h0;
		else low_cnt <= cs_n ? 16'h0 : low_cnt + 16'h1;
	end
	// counts rises per frame; a short or long frame must never leave the host
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) rise_cnt <= 6'h0;
		else if (cs_n) rise_cnt <= 6'h0;
		else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 6'h1;
	end

	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock high outside a frame");
	property p_data_hold_high;
		sclk && $past(sclk) |-> $stable(sdata);
	endproperty
	a_data_hold_high: assert property (p_data_hold_high)
		else $error("data moved while serial clock high");
	property p_data_hold_low;
		!cs_n && !sclk && !$past(sclk) && !$fell(cs_n) |-> $stable(sdata);
	endproperty
	a_data_hold_low: assert property (p_data_hold_low)
		else $error("data moved away from a falling serial clock");
	property p_sclk_half;
		$fell(sclk) |-> high_cnt == SCLK_HALF;
	endproperty
	a_sclk_half: assert property (p_sclk_half)
		else $error("serial clock high phase has wrong length");
	property p_bit_count;
		$rose(cs_n) |-> rise_cnt == spc_pkg::WORD_BITS_CNT;
	endproperty
	a_bit_count: assert property (p_bit_count)
		else $error("frame does not carry a whole word");
	property p_frame_len;
		$rose(cs_n) |-> low_cnt == 16'(SCLK_HALF * 16'h0041);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame select low for wrong time");
	property p_gap;
		$rose(cs_n) |-> cs_n [*6];
	endproperty
	a_gap: assert property (p_gap)
		else $error("frames too close together");
	property p_lead;
		$fell(cs_n) |-> !sclk [*6];
	endproperty
	a_lead: assert property (p_lead)
		else $error("serial clock rose too soon after select");
	property p_mux_release;
		!mux_oe |-> !pin_output_mux_select && !mux_level;
	endproperty
	a_mux_release: assert property (p_mux_release)
		else $error("released pin still shows a value");
endmodule // spc_chk

// ===== testbench/spc_test.sv
// self-checking bench: host registers send frames into the device end
`timescale 1ns/1ns
module spc_test;
	logic SYS_CLK, RST_N, AV_READ, AV_WRITE, AV_WAITREQUEST, tick;
	logic CLK_EN;
	logic [3:0] AV_ADDRESS;
	logic [31:0] AV_WRITEDATA, AV_READDATA;
	logic REF_DIV_TICK, FB_DIV_TICK, LOCK_DETECT, LOW_SPUR_MODE, DITHER_ENABLE, REF_DOUBLER_ENABLE;
	logic REF_HALVING_ENABLE, PD_POSITIVE, SYNTH_POWER_DOWN, CHARGE_PUMP_TRISTATE, BAND_RATE_HIGH;
	logic TIMER_FAST_LOCK, TIMER_RESYNC, FEEDBACK_FUNDAMENTAL, BAND_CLOCK_TICK, OSC_POWER_OFF;
	logic MUTE_UNTIL_LOCK, OUTB_SELECT, OUTB_ENABLE, OUTA_ENABLE;
	logic [1:0] OUTB_POWER, OUTA_POWER;
	logic [9:0] REF_DIVIDE;
	logic [3:0] CHARGE_PUMP_CURRENT, LOCK_WINDOW_NS;
	logic [5:0] LOCK_COUNT;
	logic [11:0] TIMER_DIVIDE;
	logic [6:0] OUTPUT_DIVIDE_RATIO;
	int mismatches = 0;
	int checked = 0;
	int ticks = 0;

	assign {REF_DIV_TICK, FB_DIV_TICK, LOCK_DETECT} = {3{tick}};
	spc_link_if link ();
	spc_host #(.SCLK_HALF(16'h0006)) spc_host_i (.*, .LINK(link.host));
	spc_dev spc_dev_i (.*, .LINK(link.dev));
	spc_chk #(.SCLK_HALF(16'h0006)) spc_chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .sclk(link.sclk),
		.sdata(link.sdata), .cs_n(link.cs_n), .pin_output_mux_select(link.pin_output_mux_select), .mux_oe(link.mux_oe),
		.mux_level(link.mux_level));

	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) if (BAND_CLOCK_TICK === 1'b1) ticks++;

	task automatic finish_test();
		if (mismatches == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon access; the request stands until waitrequest is seen low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge SYS_CLK);
		AV_ADDRESS <= a;
		AV_WRITEDATA <= d;
		AV_WRITE <= wr;
		AV_READ <= !wr;
		@(posedge SYS_CLK);
		while (AV_WAITREQUEST !== 1'b0) @(posedge SYS_CLK);
		q = AV_READDATA;
		AV_WRITE <= 1'b0;
		AV_READ <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		av(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic send(input logic [31:0] w);
		logic [31:0] q;
		av(1'b1, spc_pkg::ADDR_TX, w, q);
		q = 32'h1;
		while (q[0] !== 1'b0) av(1'b0, spc_pkg::ADDR_STATUS, 32'h0, q);
		// decode lands a few cycles after the select rises
		repeat (8) @(posedge SYS_CLK);
	endtask
	function automatic logic [31:0] refw(input logic [2:0] m, input logic [9:0] r, input logic db);
		return (32'(m) << spc_pkg::MUX_LSB) | (32'(r) << spc_pkg::RDIV_LSB) | (32'(db) << 13) | 32'h2;
	endfunction
	function automatic logic [31:0] bandw(input logic [1:0] m, input logic [11:0] dv);
		return 32'h0080_0003 | (32'(m) << spc_pkg::TMODE_LSB) | (32'(dv) << spc_pkg::TDIV_LSB);
	endfunction
	function automatic logic [31:0] outw(input logic [2:0] od, input logic [7:0] bs);
		return 32'h4 | (32'(od) << spc_pkg::ODIV_LSB) | (32'(bs) << spc_pkg::BSDIV_LSB);
	endfunction

	initial begin
		logic [31:0] w;
		RST_N = 1'b0;
		CLK_EN = 1'b1;
		AV_ADDRESS = 4'h0;
		AV_READ = 1'b0;
		AV_WRITE = 1'b0;
		AV_WRITEDATA = 32'h0;
		tick = 1'b0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		chk({REF_HALVING_ENABLE, PD_POSITIVE, CHARGE_PUMP_TRISTATE, FEEDBACK_FUNDAMENTAL}, 32'h5);
		chk({TIMER_FAST_LOCK, TIMER_RESYNC, REF_DIVIDE, TIMER_DIVIDE}, 32'h1001);
		chk({LOCK_COUNT, LOCK_WINDOW_NS, OUTPUT_DIVIDE_RATIO, link.mux_oe}, 32'h28a02);
		chk({OSC_POWER_OFF, MUTE_UNTIL_LOCK, OUTB_SELECT, OUTB_ENABLE, OUTB_POWER, OUTA_ENABLE, OUTA_POWER,
			REF_DOUBLER_ENABLE, SYNTH_POWER_DOWN, CHARGE_PUMP_CURRENT}, 32'h480);
		rd(4'hc, 32'h0);
		w = refw(3'h7, 10'h3ff, 1'b0) | 32'h6300_15b0;
		send(w);
		chk({LOW_SPUR_MODE, DITHER_ENABLE, REF_HALVING_ENABLE, PD_POSITIVE, CHARGE_PUMP_TRISTATE}, 32'h1d);
		chk({REF_DIVIDE, LOCK_COUNT, LOCK_WINDOW_NS}, 32'hffc56);
		chk({REF_DOUBLER_ENABLE, SYNTH_POWER_DOWN, CHARGE_PUMP_CURRENT}, 32'h3a);
		send(refw(3'h7, 10'h001, 1'b0) | 32'h40);
		rd(spc_pkg::ADDR_RX, w);
		chk({LOW_SPUR_MODE, DITHER_ENABLE, PD_POSITIVE, LOCK_COUNT, LOCK_WINDOW_NS}, 32'h68a);
		for (int m = 0; m < 4; m++) begin
			send(bandw(2'(m), m == 0 ? 12'hfff : 12'(m)));
			chk({BAND_RATE_HIGH, TIMER_FAST_LOCK, TIMER_RESYNC}, {29'h0, 1'b1, m == 1, m == 2});
			chk(TIMER_DIVIDE, m == 0 ? 32'hfff : 32'(m));
		end
		send(bandw(2'h1, 12'h0));
		send(refw(3'h7, 10'h0, 1'b0));
		rd(spc_pkg::ADDR_STATUS, 32'h2);
		chk({REF_DIVIDE, TIMER_DIVIDE}, 32'h1003);
		av(1'b1, spc_pkg::ADDR_STATUS, 32'h2, w);
		rd(spc_pkg::ADDR_STATUS, 32'h0);
		for (int k = 0; k < 8; k++) begin
			send(outw(3'(k), 8'h03));
			chk({FEEDBACK_FUNDAMENTAL, OUTPUT_DIVIDE_RATIO}, k == 7 ? 32'h40 : 32'h1 << k);
		end
		// reserved divider code keeps the ratio; second output needs the first enabled
		send(outw(3'h7, 8'h03) | 32'h0000_0f58);
		chk({OSC_POWER_OFF, MUTE_UNTIL_LOCK, OUTB_SELECT, OUTB_ENABLE, OUTB_POWER, OUTA_ENABLE, OUTA_POWER},
			32'h1cb);
		send(outw(3'h0, 8'hff));
		rd(spc_pkg::ADDR_STATUS, 32'h2);
		send(32'hffff_fff5);
		chk({REF_DIVIDE, OUTPUT_DIVIDE_RATIO}, 32'hc0);
		rd(spc_pkg::ADDR_TX, 32'hffff_fff5);
		send(refw(3'h7, 10'h001, 1'b1));
		send(outw(3'h3, 8'h03));
		chk(OUTPUT_DIVIDE_RATIO, 32'h40);
		send(32'h0);
		chk(OUTPUT_DIVIDE_RATIO, 32'h8);
		w = 32'(ticks);
		tick <= 1'b1;
		repeat (30) @(posedge SYS_CLK);
		tick <= 1'b0;
		repeat (5) @(posedge SYS_CLK);
		chk(32'(ticks) - w, 32'ha);
		// frozen clock enable must swallow every reference tick
		CLK_EN <= 1'b0;
		tick <= 1'b1;
		repeat (20) @(posedge SYS_CLK);
		CLK_EN <= 1'b1;
		tick <= 1'b0;
		@(posedge SYS_CLK);
		chk(32'(ticks) - w, 32'ha);
		for (int m = 0; m < 7; m++) begin
			send(refw(3'(m), 10'h001, 1'b0));
			tick <= 1'b1;
			repeat (3) @(posedge SYS_CLK);
			chk(link.mux_level, 32'(m inside {1, 3, 4, 6}));
			tick <= 1'b0;
			repeat (3) @(posedge SYS_CLK);
			chk({link.mux_oe, link.mux_level}, {30'h0, !(m == 0 || m == 5), m == 1});
		end
		finish_test();
	end

	initial begin
		#400000;
		mismatches++;
		finish_test();
	end
endmodule // spc_test
